// File: verilog/hpi_pkg.sv
/*
 * Constants for the host port interrupt control and pin monitor block:
 * register offsets, bit positions and reset values.
 * Assumes one 8-bit register port on the local processor side.
 */
`default_nettype none

package hpi_pkg;
    // Register offsets on the local register port
    localparam logic [3:0] ADDR_IRQ_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PIN_MONITOR = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_HOST_CTRL = 4'h4;

    // Bit positions in the interrupt control register
    localparam int BIT_GATE_A20 = 7;
    localparam int BIT_RESET_FLAG = 6;
    localparam int BIT_PWRDN_FLAG = 5;
    localparam int BIT_ABORT_FLAG = 4;
    localparam int BIT_CH3_EN = 3;
    localparam int BIT_CH2_EN = 2;
    localparam int BIT_CH1_EN = 1;
    localparam int BIT_ERR_EN = 0;

    // Bit positions in the host control register
    localparam int BIT_SW_RESET = 0;
    localparam int BIT_SW_SHUTDOWN = 1;
    localparam int BIT_BIDIR_SEL = 2;

    // Event status bits
    localparam int EV_ERROR = 0;
    localparam int EV_CH1 = 1;
    localparam int EV_CH2 = 2;
    localparam int EV_CH3 = 3;
    localparam int EV_COUNT = 4;

    // Pin monitor bit positions
    localparam int PIN_FRAME = 7;
    localparam int PIN_CLKRUN = 6;
    localparam int PIN_SERIRQ = 5;
    localparam int PIN_RESET = 4;
    localparam int PIN_PWRDN = 3;
    localparam int PIN_WAKE = 2;
    localparam int PIN_SMI = 1;
    localparam int PIN_SCI = 0;
    localparam int PIN_COUNT = 8;

    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] PIN_RESET_VALUE = 8'hff;
endpackage : hpi_pkg

`default_nettype wire

// File: verilog/hpi_irq_monitor.sv
/*
 * Host port interrupt flags, enables and pin monitor.
 * Assumes host pins asynchronous to ref_clk; they are synchronised here.
 * Receive-complete pulses arrive from logic on ref_clk.
 * Register map: control, pin monitor, status, mask, host control.
 * Status bits are write-one-to-clear; the mask enables the irq output.
 * Read data stand for one cycle after the read strobe, zero otherwise.
 * Host pins take two clock edges before an edge event is seen.
 * The gate level shares the synchroniser with the eight host pins.
 * Channel done pulses are one cycle long, on ref_clk.
 * Flags clear by a written zero only after a control read showed them set.
 * Writing one to a flag bit has no effect.
 * Requests to the local processor are registered one cycle after cause.
 */
// The address map and the strobed register port were chosen for this implementation.
// Behaviour
// - Reset pin falling edge sets reset flag
// - Reset flag clears by zero after one read
// - Powerdown pin falling edge sets powerdown flag
// - Powerdown flag clears by zero or resets
// - Frame fall during cycle sets abort flag
// - Abort flag clears by zero or resets
// - Abort flag also clears on shutdowns
// - Error flags accept only written zero
// - Error enable gates error interrupt
// - Channel 3 enable and select gate sources
// - Select one adds bidir receive to channel 3
// - Channel 2 enable gates channel 2 interrupt
// - Channel 1 enable gates channel 1 interrupt
// - Control bits 6..0 govern local interrupts
// - Bit 7 shows live gate level always
`default_nettype none

module hpi_irq_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] host_pins,
    input wire logic gate_addr20_level,
    input wire logic host_cycle_active,
    input wire logic ch1_receive_done,
    input wire logic ch2_receive_done,
    input wire logic ch3_receive_done,
    input wire logic bidir_receive_done,
    output logic error_irq,
    output logic ch1_receive_irq,
    output logic ch2_receive_irq,
    output logic ch3_receive_irq,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [8:0] pin_meta_q;
    logic [8:0] pin_sync_q;
    logic [8:0] pin_prev_q;
    logic [8:0] pin_async;

    assign pin_async = {gate_addr20_level, host_pins};

    // Pin order: gate level on top, then frame down to sci
    // Two flops per pin, then one more for edge detection
    // All pins reset high, so leaving reset makes a fall only on a pin that is already low
    // Only the second and third flops feed logic; the first may be metastable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta_q <= {1'b1, hpi_pkg::PIN_RESET_VALUE};
            pin_sync_q <= {1'b1, hpi_pkg::PIN_RESET_VALUE};
            pin_prev_q <= {1'b1, hpi_pkg::PIN_RESET_VALUE};
        end else begin
            pin_meta_q <= pin_async;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic reset_fall;
    logic pwrdn_fall;
    logic frame_fall;
    logic cycle_meta_q;
    logic cycle_sync_q;

    // Cycle-active comes from the link side too
    // Two flops, like the pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cycle_meta_q <= 1'b0;
            cycle_sync_q <= 1'b0;
        end else begin
            cycle_meta_q <= host_cycle_active;
            cycle_sync_q <= cycle_meta_q;
        end
    end

    // Falling edges of the synchronised pins
    // Each is one cycle wide, two edges after the pin moves
    assign reset_fall = pin_prev_q[hpi_pkg::PIN_RESET] & ~pin_sync_q[hpi_pkg::PIN_RESET];
    assign pwrdn_fall = pin_prev_q[hpi_pkg::PIN_PWRDN] & ~pin_sync_q[hpi_pkg::PIN_PWRDN];
    assign frame_fall = pin_prev_q[hpi_pkg::PIN_FRAME] & ~pin_sync_q[hpi_pkg::PIN_FRAME];

    ////////////////////////////////////////////////////////////////////////
    // Register writes and read tracking

    // Software registers live here; flags are in the next section
    // Reset value of the enables
    localparam logic [3:0] EN_RESET = 4'h0;
    // Reset value of the host control bits
    localparam logic [2:0] HOST_RESET = 3'h0;
    // Reset value of mask and status
    localparam logic [3:0] EV_RESET = 4'h0;
    // Slot of the gate level above the eight host pins
    localparam int GATE_IDX = hpi_pkg::PIN_COUNT;

    // Enable bits 3..0 of the control register
    logic [3:0] en_q;
    // Error flags, one register each so that one process owns each
    logic reset_flag_q;
    logic pwrdn_flag_q;
    logic abort_flag_q;
    // Host control: bidir select, sw shutdown, sw reset
    logic [2:0] host_ctrl_q;
    // Event mask and sticky event status
    logic [3:0] mask_q;
    logic [3:0] status_q;
    // Flags that the last control read returned as one
    logic [2:0] flag_seen_q;

    // Decoded strobes of the register port
    logic flag_rd;
    logic ctrl_wr;
    logic host_wr;
    logic mask_wr;
    logic status_wr;

    // Host reset and shutdown levels after synchronising
    logic hw_reset;
    logic hw_shutdown;

    // Control register as software sees it
    logic [7:0] ctrl_view;
    logic any_flag;

    // Address decode; writes to the pin monitor are ignored
    assign flag_rd = reg_rd && (reg_addr == hpi_pkg::ADDR_IRQ_CONTROL);
    assign ctrl_wr = reg_wr && (reg_addr == hpi_pkg::ADDR_IRQ_CONTROL);
    assign host_wr = reg_wr && (reg_addr == hpi_pkg::ADDR_HOST_CTRL);
    assign mask_wr = reg_wr && (reg_addr == hpi_pkg::ADDR_IRQ_MASK);
    assign status_wr = reg_wr && (reg_addr == hpi_pkg::ADDR_IRQ_STATUS);

    // Reset and powerdown pins are active low
    assign hw_reset = ~pin_sync_q[hpi_pkg::PIN_RESET];
    assign hw_shutdown = ~pin_sync_q[hpi_pkg::PIN_PWRDN];

    // Channel and error enables
    // Flag bits 6..4 of a control write go to the clear logic only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q <= EN_RESET;
        end else if (ctrl_wr) begin
            en_q <= reg_wdata[hpi_pkg::BIT_CH3_EN:hpi_pkg::BIT_ERR_EN];
        end
    end

    // Host control; sw reset and sw shutdown drop while reset_n is low
    // A write in the same cycle wins, so software sees its own value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_ctrl_q <= HOST_RESET;
        end else if (host_wr) begin
            host_ctrl_q <= reg_wdata[hpi_pkg::BIT_BIDIR_SEL:hpi_pkg::BIT_SW_RESET];
        end else if (hw_reset) begin
            host_ctrl_q[hpi_pkg::BIT_SW_RESET] <= 1'b0;
            host_ctrl_q[hpi_pkg::BIT_SW_SHUTDOWN] <= 1'b0;
        end
    end

    // Event mask, one bit per status bit
    // Mask zero keeps irq low, but status still records the event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= EV_RESET;
        end else if (mask_wr) begin
            mask_q <= reg_wdata[hpi_pkg::EV_COUNT-1:0];
        end
    end

    // Remember which flags were read as one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_seen_q <= 3'h0;
        end else if (flag_rd) begin
            flag_seen_q <= ctrl_view[hpi_pkg::BIT_RESET_FLAG:hpi_pkg::BIT_ABORT_FLAG];
        end else if (ctrl_wr) begin
            flag_seen_q <= 3'h0;
        end
    end

    logic sw_reset;
    logic sw_shutdown;
    logic [2:0] flag_clr;

    assign sw_reset = host_ctrl_q[hpi_pkg::BIT_SW_RESET];
    assign sw_shutdown = host_ctrl_q[hpi_pkg::BIT_SW_SHUTDOWN];
    // Only a written zero after a one was read clears
    assign flag_clr = {3{ctrl_wr}} & ~reg_wdata[6:4] & flag_seen_q;

    ////////////////////////////////////////////////////////////////////////
    // Error flags: a set beats a clear in the same cycle
    // Level clears (reset_n held low for powerdown and abort, powerdown_n for abort only)
    // win again on the next cycle, so a flag set during such a hold does not survive it

    // Reset flag: set by a reset_n fall, cleared only by software
    // Neither sw reset nor sw shutdown touches it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_flag_q <= 1'b0;
        end else if (reset_fall) begin
            reset_flag_q <= 1'b1;
        end else if (flag_clr[2]) begin
            reset_flag_q <= 1'b0;
        end
    end

    // Powerdown flag: also cleared by a hardware or software reset
    // Its own fall wins over a reset_n that is still low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwrdn_flag_q <= 1'b0;
        end else if (pwrdn_fall) begin
            pwrdn_flag_q <= 1'b1;
        end else if (flag_clr[1] || hw_reset || sw_reset) begin
            pwrdn_flag_q <= 1'b0;
        end
    end

    // Abort flag: only a frame fall inside a host cycle sets it
    // Resets and both kinds of shutdown clear it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abort_flag_q <= 1'b0;
        end else if (frame_fall && cycle_sync_q) begin
            abort_flag_q <= 1'b1;
        end else if (flag_clr[0] || hw_reset || sw_reset) begin
            abort_flag_q <= 1'b0;
        end else if (hw_shutdown || sw_shutdown) begin
            abort_flag_q <= 1'b0;
        end
    end

    // Any error flag raised; feeds the error request below
    assign any_flag = reset_flag_q | pwrdn_flag_q | abort_flag_q;

    // Control register as read; bit 7 is the live gate level
    assign ctrl_view = {pin_sync_q[GATE_IDX], reset_flag_q, pwrdn_flag_q,
        abort_flag_q, en_q};

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    logic ch3_source;

    // Bidirectional receive joins channel 3 only when selected
    // Select zero leaves channel 3 to its own input register
    assign ch3_source = ch3_receive_done
        | (bidir_receive_done & host_ctrl_q[hpi_pkg::BIT_BIDIR_SEL]);

    // Requests follow enables and sources by one cycle
    // error_irq is a level, the channel requests are one-cycle pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            error_irq <= 1'b0;
            ch1_receive_irq <= 1'b0;
            ch2_receive_irq <= 1'b0;
            ch3_receive_irq <= 1'b0;
        end else begin
            error_irq <= en_q[hpi_pkg::BIT_ERR_EN] & any_flag;
            ch1_receive_irq <= en_q[hpi_pkg::BIT_CH1_EN] & ch1_receive_done;
            ch2_receive_irq <= en_q[hpi_pkg::BIT_CH2_EN] & ch2_receive_done;
            ch3_receive_irq <= en_q[hpi_pkg::BIT_CH3_EN] & ch3_source;
        end
    end

    // Status set and clear per event
    logic [3:0] ev_set;
    logic [3:0] ev_clr;

    assign ev_set = {ch3_receive_irq, ch2_receive_irq, ch1_receive_irq, error_irq};
    assign ev_clr = status_wr ? reg_wdata[hpi_pkg::EV_COUNT-1:0] : EV_RESET;

    // Sticky status per event, set wins over clear
    // A clear in the set cycle loses, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < hpi_pkg::EV_COUNT; gi++) begin : g_ev
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    status_q[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Level interrupt, high while an unmasked status bit is set
    assign irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    // Unmapped addresses and idle cycles return zero

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= hpi_pkg::RESET_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                hpi_pkg::ADDR_IRQ_CONTROL: reg_rdata <= ctrl_view;
                hpi_pkg::ADDR_PIN_MONITOR: reg_rdata <= pin_sync_q[7:0];
                hpi_pkg::ADDR_IRQ_STATUS: reg_rdata <= {4'h0, status_q};
                hpi_pkg::ADDR_IRQ_MASK: reg_rdata <= {4'h0, mask_q};
                hpi_pkg::ADDR_HOST_CTRL: reg_rdata <= {5'h00, host_ctrl_q};
                default: reg_rdata <= hpi_pkg::RESET_ZERO;
            endcase
        end else begin
            reg_rdata <= hpi_pkg::RESET_ZERO;
        end
    end

endmodule : hpi_irq_monitor

`default_nettype wire

// File: tb/hpi_irq_monitor_properties.sv
/* Port checker for the host port interrupt block.
   Sees only the block's ports; bound from the testbench. */
`default_nettype none
module hpi_irq_monitor_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] host_pins,
    input wire logic gate_addr20_level,
    input wire logic ch1_receive_done,
    input wire logic ch2_receive_done,
    input wire logic ch3_receive_done,
    input wire logic bidir_receive_done,
    input wire logic error_irq,
    input wire logic ch1_receive_irq,
    input wire logic ch2_receive_irq,
    input wire logic ch3_receive_irq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Pins settled long enough to pass the synchroniser
    sequence pins_calm;
        $stable(host_pins)[*4];
    endsequence
    sequence gate_calm;
        $stable(gate_addr20_level)[*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    pin_mirror_a: assert property (pins_calm ##0 (reg_rd && reg_addr == 4'h1)
        |=> reg_rdata == $past(host_pins)) else $error("pin monitor wrong");
    gate_mirror_a: assert property (gate_calm ##0 (reg_rd && reg_addr == 4'h0)
        |=> reg_rdata[7] == $past(gate_addr20_level)) else $error("gate bit wrong");
    ch1_cause_a: assert property (ch1_receive_irq |-> $past(ch1_receive_done))
        else $error("channel 1 request without receive");
    ch2_cause_a: assert property (ch2_receive_irq |-> $past(ch2_receive_done))
        else $error("channel 2 request without receive");
    ch3_cause_a: assert property (ch3_receive_irq |-> $past(ch3_receive_done)
        || $past(bidir_receive_done)) else $error("channel 3 request without receive");
    irq_cause_a: assert property ($rose(irq) |-> $past(reg_wr) || $past(error_irq)
        || $past(ch1_receive_irq | ch2_receive_irq | ch3_receive_irq))
        else $error("interrupt rose without cause");
endmodule : hpi_irq_monitor_properties
`default_nettype wire

// File: tb/hpi_host_model.sv
/* Host chipset model driving the host pins on its own 80 ns link clock.
   Assumes the testbench calls its tasks hierarchically. */
`default_nettype none
module hpi_host_model (
    output logic [7:0] host_pins,
    output logic gate_addr20_level,
    output logic host_cycle_active
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lclk = 1'b0;
    // Idle pins high, link clock free
    initial begin
        host_pins = 8'hff;
        gate_addr20_level = 1'b1;
        host_cycle_active = 1'b0;
        forever #40 lclk = ~lclk;
    end
    // Low pulse of two link periods on one pin
    task pulse(input int b);
        @(posedge lclk);
        host_pins[b] = 1'b0;
        repeat (2) @(posedge lclk);
        host_pins[b] = 1'b1;
    endtask : pulse
    // Frame drop inside or outside a transfer cycle
    task abort_cycle(input logic busy);
        @(posedge lclk);
        host_cycle_active = busy;
        pulse(7);
        host_cycle_active = 1'b0;
    endtask : abort_cycle
    // Drive all eight pins at once
    task set_pins(input logic [7:0] v);
        host_pins = v;
    endtask : set_pins
    task set_gate(input logic v);
        gate_addr20_level = v;
    endtask : set_gate
endmodule : hpi_host_model
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench for the host port interrupt block.
   Assumes the host model and port checker are compiled first. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] done = 4'h0;
    logic [7:0] reg_rdata, host_pins;
    logic [2:0] chi;
    logic gate, cyc, error_irq, irq;
    int bad_count = 0;
    int cmp_count = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    hpi_host_model u_host (.host_pins(host_pins), .gate_addr20_level(gate),
        .host_cycle_active(cyc));
    hpi_irq_monitor i_hpi_irq_monitor (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_pins(host_pins), .gate_addr20_level(gate), .host_cycle_active(cyc),
        .ch1_receive_done(done[0]), .ch2_receive_done(done[1]), .ch3_receive_done(done[2]),
        .bidir_receive_done(done[3]), .error_irq(error_irq), .ch1_receive_irq(chi[0]),
        .ch2_receive_irq(chi[1]), .ch3_receive_irq(chi[2]), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    // Register port cycles
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask : rd
    // One receive pulse, then the channel requests
    task fire(input int c, input logic [2:0] ex);
        @(posedge ref_clk);
        done[c] <= 1'b1;
        @(posedge ref_clk);
        done[c] <= 1'b0;
        #1 chk("ch_irq", {5'h00, ex}, {5'h00, chi});
    endtask : fire
    task wait_err;
        int i;
        for (i = 0; i < 60 && error_irq !== 1'b1; i++) @(posedge ref_clk);
        if (i == 60) begin
            bad_count++;
            results();
        end
    endtask : wait_err
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(4'h0, 8'h80);
        rd(4'hf, 8'h00);
        rd(4'h1, 8'hff);
        wr(4'h0, 8'h7f);
        rd(4'h0, 8'h8f);
        $display("test registers done");
        fire(0, 3'b001);
        fire(1, 3'b010);
        fire(2, 3'b100);
        fire(3, 3'b000);
        wr(4'h4, 8'h04);
        fire(3, 3'b100);
        wr(4'h0, 8'h00);
        for (int c = 0; c < 4; c++) fire(c, 3'b000);
        $display("test channels done");
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h01);
        u_host.pulse(4);
        wait_err();
        chk("irq", 8'h00, {7'h00, irq});
        wr(4'h0, 8'h01);
        rd(4'h0, 8'hc1);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h81);
        rd(4'h2, 8'h0f);
        wr(4'h3, 8'h01);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wr(4'h2, 8'h0f);
        #1 chk("irq", 8'h00, {7'h00, irq});
        $display("test reset flag done");
        u_host.pulse(3);
        rd(4'h0, 8'ha1);
        u_host.pulse(4);
        rd(4'h0, 8'hc1);
        wr(4'h0, 8'h01);
        u_host.abort_cycle(1'b0);
        rd(4'h0, 8'h81);
        u_host.abort_cycle(1'b1);
        rd(4'h0, 8'h91);
        u_host.pulse(3);
        rd(4'h0, 8'ha1);
        wr(4'h4, 8'h01);
        wr(4'h4, 8'h00);
        rd(4'h0, 8'h81);
        u_host.abort_cycle(1'b1);
        wr(4'h4, 8'h02);
        wr(4'h4, 8'h00);
        rd(4'h0, 8'h81);
        u_host.abort_cycle(1'b1);
        rd(4'h0, 8'h91);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h81);
        wr(4'h0, 8'h00);
        u_host.abort_cycle(1'b1);
        chk("error_irq", 8'h00, {7'h00, error_irq});
        wr(4'h0, 8'h11);
        wait_err();
        u_host.set_gate(1'b0);
        repeat (4) @(posedge ref_clk);
        rd(4'h0, 8'h11);
        u_host.set_pins(8'h9a);
        repeat (4) @(posedge ref_clk);
        rd(4'h1, 8'h9a);
        u_host.set_pins(8'h5d);
        repeat (4) @(posedge ref_clk);
        rd(4'h1, 8'h5d);
        u_host.set_pins(8'hff);
        $display("test host events done");
        results();
    end
endmodule : testbench
bind hpi_irq_monitor hpi_irq_monitor_properties u_props (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_pins(host_pins), .gate_addr20_level(gate_addr20_level),
    .ch1_receive_done(ch1_receive_done), .ch2_receive_done(ch2_receive_done),
    .ch3_receive_done(ch3_receive_done), .bidir_receive_done(bidir_receive_done),
    .error_irq(error_irq), .ch1_receive_irq(ch1_receive_irq),
    .ch2_receive_irq(ch2_receive_irq), .ch3_receive_irq(ch3_receive_irq), .irq(irq));
`default_nettype wire
